/* pps_pkg.sv */
package pps_pkg;

  // Register port
  localparam int unsigned PPS_AW       = 4;
  localparam int unsigned PPS_DW       = 32;
  localparam logic [3:0]  PPS_REG_CTRL = 4'h0;
  localparam logic [3:0]  PPS_REG_DIV  = 4'h1;
  localparam logic [3:0]  PPS_REG_LEN  = 4'h2;
  localparam logic [3:0]  PPS_REG_ADDR = 4'h3;
  localparam logic [3:0]  PPS_REG_STAT = 4'h4;
  localparam logic [3:0]  PPS_REG_DATA = 4'h5;

  // Control fields
  localparam int unsigned PPS_CTRL_START = 0;
  localparam int unsigned PPS_CTRL_TGT   = 1;
  localparam int unsigned PPS_CTRL_PRES  = 2;
  localparam int unsigned PPS_CTRL_PUSED = 3;

  // Status fields
  localparam int unsigned PPS_ST_BUSY   = 0;
  localparam int unsigned PPS_ST_DONE   = 1;
  localparam int unsigned PPS_ST_TGT    = 2;
  localparam int unsigned PPS_ST_RECOV  = 3;
  localparam int unsigned PPS_ST_SEL    = 4;
  localparam int unsigned PPS_ST_TAPRST = 5;

  // Reset values
  localparam logic [7:0]  PPS_DIV_RST  = 8'h03;
  localparam logic [15:0] PPS_LEN_RST  = 16'h0100;
  localparam logic [23:0] PPS_ADDR_RST = 24'h000000;

  // Serial fetch framing
  localparam logic [7:0]  PPS_READ_CMD = 8'h03;
  localparam logic [5:0]  PPS_HDR_LAST = 6'h1f;
  localparam logic [2:0]  PPS_BYTE_LAST = 3'h7;

  // Test-access port
  localparam int unsigned PPS_IR_W     = 4;
  localparam logic [3:0]  PPS_IR_IDC   = 4'h1;
  localparam logic [3:0]  PPS_IR_CAP   = 4'h1;
  localparam logic [31:0] PPS_IDCODE   = 32'h00000001; // Arbitrary value

  typedef enum logic [2:0] {
    PPS_IDLE, PPS_HDR, PPS_BODY, PPS_TGT, PPS_FIN
  } pps_state_t;

  typedef enum logic [3:0] {
    PPS_TLR, PPS_RTI, PPS_SDS, PPS_CDR, PPS_SHD, PPS_E1D, PPS_PDR, PPS_E2D,
    PPS_UDR, PPS_SIS, PPS_CIR, PPS_SHI, PPS_E1I, PPS_PIR, PPS_E2I, PPS_UIR
  } pps_tap_t;

endpackage : pps_pkg

/* pps_sync.sv */
`timescale 1ns/1ps
module pps_sync #(
  parameter int unsigned W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and control
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         ce,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (!rstn) begin
        s1[i] <= INIT[i];
        s2[i] <= INIT[i];
        s3[i] <= INIT[i];
        q[i]  <= INIT[i];
      end else if (ce) begin
        s1[i] <= d[i];
        s2[i] <= s1[i];
        s3[i] <= s2[i];
        // Accept a change only when stages two and three agree
        if (s2[i] == s3[i]) begin
          q[i] <= s3[i];
        end
      end
    end
  end

endmodule : pps_sync

/* pps_tap.sv */
`timescale 1ns/1ps
module pps_tap
  import pps_pkg::*;
(
  // Test clock domain
  input  wire logic tck,
  input  wire logic tms,
  input  wire logic tdi,
  input  wire logic test_port_reset_n,
  input  wire logic tap_port_select,
  input  wire logic dev_rstn,
  output logic      tdo,
  output logic      tdo_oe,
  output logic      tap_in_reset,
  // Processor debug path
  input  wire logic dbg_tdo,
  output logic      dbg_tms,
  output logic      dbg_tdi,
  output logic      dbg_trst_n
);

  logic [2:0]          pin_f;
  logic                sel_f;
  logic                trst_f;
  logic                drst_f;
  logic                tap_rst;
  pps_tap_t            tstate;
  logic [PPS_IR_W-1:0] ir;
  logic [PPS_IR_W-1:0] ir_sh;
  logic [31:0]         dr;
  logic                sh_bit;

  // Pins and device reset enter the test clock domain
  pps_sync #(.W(3), .INIT(3'h0)) u_sync (
    .clk  (tck),
    .rstn (1'b1),
    .ce   (1'b1),
    .d    ({tap_port_select, test_port_reset_n, dev_rstn}),
    .q    (pin_f)
  );
  assign sel_f  = pin_f[2];
  assign trst_f = pin_f[1];
  assign drst_f = pin_f[0];

  // Device reset holds the controller in reset
  assign tap_rst = !trst_f || !drst_f;
  assign sh_bit  = (tstate == PPS_SHI) ? ir_sh[0] : dr[0];

  always_ff @(posedge tck) begin
    tap_in_reset <= tap_rst;
  end

  always_ff @(posedge tck) begin
    if (tap_rst) begin
      tstate <= PPS_TLR;
    end else begin
      case (tstate)
        PPS_TLR: tstate <= tms ? PPS_TLR : PPS_RTI;
        PPS_RTI: tstate <= tms ? PPS_SDS : PPS_RTI;
        PPS_SDS: tstate <= tms ? PPS_SIS : PPS_CDR;
        PPS_CDR: tstate <= tms ? PPS_E1D : PPS_SHD;
        PPS_SHD: tstate <= tms ? PPS_E1D : PPS_SHD;
        PPS_E1D: tstate <= tms ? PPS_UDR : PPS_PDR;
        PPS_PDR: tstate <= tms ? PPS_E2D : PPS_PDR;
        PPS_E2D: tstate <= tms ? PPS_UDR : PPS_SHD;
        PPS_UDR: tstate <= tms ? PPS_SDS : PPS_RTI;
        PPS_SIS: tstate <= tms ? PPS_TLR : PPS_CIR;
        PPS_CIR: tstate <= tms ? PPS_E1I : PPS_SHI;
        PPS_SHI: tstate <= tms ? PPS_E1I : PPS_SHI;
        PPS_E1I: tstate <= tms ? PPS_UIR : PPS_PIR;
        PPS_PIR: tstate <= tms ? PPS_E2I : PPS_PIR;
        PPS_E2I: tstate <= tms ? PPS_UIR : PPS_SHI;
        PPS_UIR: tstate <= tms ? PPS_SDS : PPS_RTI;
        default: tstate <= PPS_TLR;
      endcase
    end
  end

  always_ff @(posedge tck) begin
    if (tap_rst || tstate == PPS_TLR) begin
      ir    <= PPS_IR_IDC;
      ir_sh <= PPS_IR_CAP;
    end else if (tstate == PPS_CIR) begin
      ir_sh <= PPS_IR_CAP;
    end else if (tstate == PPS_SHI) begin
      ir_sh <= {tdi, ir_sh[PPS_IR_W-1:1]};
    end else if (tstate == PPS_UIR) begin
      ir <= ir_sh;
    end
  end

  // Identity register or one-bit bypass
  always_ff @(posedge tck) begin
    if (tap_rst) begin
      dr <= 32'h0;
    end else if (tstate == PPS_CDR) begin
      dr <= (ir == PPS_IR_IDC) ? PPS_IDCODE : 32'h0;
    end else if (tstate == PPS_SHD) begin
      if (ir == PPS_IR_IDC) begin
        dr <= {tdi, dr[31:1]};
      end else begin
        dr[0] <= tdi;
      end
    end
  end

  // Data out changes on the falling test clock edge
  always_ff @(negedge tck) begin
    if (tap_rst && sel_f) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      tdo    <= sel_f ? sh_bit : dbg_tdo;
      tdo_oe <= sel_f ? (tstate == PPS_SHD || tstate == PPS_SHI) : 1'b1;
    end
  end

  always_ff @(posedge tck) begin
    dbg_tms    <= sel_f ? 1'b1 : tms;
    dbg_tdi    <= sel_f ? 1'b1 : tdi;
    dbg_trst_n <= !sel_f && trst_f && drst_f;
  end

  tap_hold_a: assert property (@(posedge tck) !drst_f |=>
    tstate == PPS_TLR) else $error("tap left reset under device reset");
  dbg_route_a: assert property (@(posedge tck) !sel_f |=>
    dbg_tms == $past(tms) && dbg_tdi == $past(tdi))
    else $error("debug path not routed");
  fab_route_a: assert property (@(posedge tck) sel_f |=>
    !dbg_trst_n) else $error("debug path not held with fabric selected");

endmodule : pps_tap

/* pps_top.sv */
`timescale 1ns/1ps
// Operation
// - Select high routes test access to fabric port, low to debug port.
// - Under device reset test pins live, but port controller held reset.
// - Programming serial block runs in initiator or target mode.
// - Initiator mode masters external flash and reads programming data.
// - Target mode: remote master starts transfer, block accepts its data.
// - Recovery pin low forces initiator mode and reload from flash.
// - Device drives divided serial clock, data out, select; samples din.
// - Reserved probe pins become tristated outputs.
// - Unreserved probe pins are user pins; unused ones tristate, pulled up.
module pps_top
  import pps_pkg::*;
(
  // Clock, reset, enable
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              ce,
  // Register port
  input  wire logic [PPS_AW-1:0] addr,
  input  wire logic [PPS_DW-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [PPS_DW-1:0] rdata,
  // Test access
  input  wire logic              tck,
  input  wire logic              tms,
  input  wire logic              tdi,
  input  wire logic              test_port_reset_n,
  input  wire logic              tap_port_select,
  output logic                   tdo,
  output logic                   tdo_oe,
  // Processor debug path
  input  wire logic              dbg_tdo,
  output logic                   dbg_tms,
  output logic                   dbg_tdi,
  output logic                   dbg_trst_n,
  // Programming serial port
  input  wire logic              prog_serial_clk_i,
  output logic                   prog_serial_clk_o,
  output logic                   prog_serial_clk_oe,
  input  wire logic              prog_target_sel_n_i,
  output logic                   prog_target_sel_n_o,
  output logic                   prog_target_sel_n_oe,
  input  wire logic              prog_serial_din,
  output logic                   prog_serial_dout,
  output logic                   prog_serial_dout_oe,
  input  wire logic              recovery_boot_n,
  // Programming byte stream
  output logic      [7:0]        prog_byte,
  output logic                   prog_byte_valid,
  // Live-probe pins
  input  wire logic [1:0]        user_probe_o,
  input  wire logic [1:0]        user_probe_oe,
  output logic      [1:0]        probe_o,
  output logic      [1:0]        probe_oe,
  output logic      [1:0]        probe_ie,
  output logic      [1:0]        probe_pu
);

  import pps_pkg::*;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  //////////////////////////////////////////////////////////////////////////
  logic [4:0]  pin_f;
  logic        recov_f;
  logic        sclk_f;
  logic        tsel_f;
  logic        din_f;
  logic        taprst_f;
  logic        recov_prev;
  logic        recov_pend;
  logic        sclk_prev;
  logic        sclk_rise;
  logic        tgt_mode;
  logic        ctrl_tgt;
  logic        prb_res;
  logic        prb_used;
  logic [7:0]  div;
  logic [15:0] len;
  logic [23:0] faddr;
  logic        done;
  logic        start;
  logic        ctrl_wr;
  pps_state_t  state;
  logic [7:0]  div_cnt;
  logic        tick;
  logic [5:0]  bitcnt;
  logic [15:0] bytecnt;
  logic [31:0] shreg;
  logic [7:0]  rx_byte;
  logic        taprst_f_raw;

  //////////////////////////////////////////////////////////////////////////
  // Test access port on its own clock
  pps_tap u_tap (
    .tck               (tck),
    .tms               (tms),
    .tdi               (tdi),
    .test_port_reset_n (test_port_reset_n),
    .tap_port_select   (tap_port_select),
    .dev_rstn          (rstn),
    .tdo               (tdo),
    .tdo_oe            (tdo_oe),
    .tap_in_reset      (taprst_f_raw),
    .dbg_tdo           (dbg_tdo),
    .dbg_tms           (dbg_tms),
    .dbg_tdi           (dbg_tdi),
    .dbg_trst_n        (dbg_trst_n)
  );

  // Pins and test-domain status into this domain
  pps_sync #(.W(5), .INIT(5'h1e)) u_pins (
    .clk  (clk),
    .rstn (rstn),
    .ce   (ce),
    .d    ({recovery_boot_n, prog_target_sel_n_i, taprst_f_raw,
            prog_serial_clk_i, prog_serial_din}),
    .q    (pin_f)
  );
  assign recov_f  = pin_f[4];
  assign tsel_f   = pin_f[3];
  assign taprst_f = pin_f[2];
  assign sclk_f   = pin_f[1];
  assign din_f    = pin_f[0];

  //////////////////////////////////////////////////////////////////////////
  // Mode selection
  assign tgt_mode  = ctrl_tgt && recov_f;
  assign ctrl_wr   = wr && addr == PPS_REG_CTRL;
  assign start     = ctrl_wr && wdata[PPS_CTRL_START];
  assign tick      = div_cnt == div;
  assign sclk_rise = sclk_f && !sclk_prev;
  assign rx_byte   = {shreg[6:0], (state == PPS_TGT) ? din_f : prog_serial_din};

  always_ff @(posedge clk) begin
    if (!rstn) begin
      recov_prev <= 1'b1;
      sclk_prev  <= 1'b0;
    end else if (ce) begin
      recov_prev <= recov_f;
      sclk_prev  <= sclk_f;
    end
  end

  // Recovery request stays pending until a fetch starts
  always_ff @(posedge clk) begin
    if (!rstn) begin
      recov_pend <= 1'b0;
    end else if (ce) begin
      if (recov_prev && !recov_f) begin
        recov_pend <= 1'b1;
      end else if (state == PPS_HDR) begin
        recov_pend <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_tgt <= 1'b0;
      prb_res  <= 1'b0;
      prb_used <= 1'b0;
      div      <= PPS_DIV_RST;
      len      <= PPS_LEN_RST;
      faddr    <= PPS_ADDR_RST;
    end else if (ce && wr) begin
      case (addr)
        PPS_REG_CTRL: begin
          ctrl_tgt <= wdata[PPS_CTRL_TGT];
          prb_res  <= wdata[PPS_CTRL_PRES];
          prb_used <= wdata[PPS_CTRL_PUSED];
        end
        PPS_REG_DIV:  div   <= wdata[7:0];
        PPS_REG_LEN:  len   <= wdata[15:0];
        PPS_REG_ADDR: faddr <= wdata[23:0];
        default: ;
      endcase
    end
  end

  // Done flag: a finish in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (!rstn) begin
      done <= 1'b0;
    end else if (ce) begin
      if (state == PPS_FIN) begin
        done <= 1'b1;
      end else if (wr && addr == PPS_REG_STAT && wdata[PPS_ST_DONE]) begin
        done <= 1'b0;
      end
    end
  end

  // Read data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata <= '0;
    end else if (ce) begin
      rdata <= '0;
      if (rd) begin
        case (addr)
          PPS_REG_CTRL: rdata[PPS_CTRL_PUSED:PPS_CTRL_TGT] <=
                          {prb_used, prb_res, ctrl_tgt};
          PPS_REG_DIV:  rdata[7:0]  <= div;
          PPS_REG_LEN:  rdata[15:0] <= len;
          PPS_REG_ADDR: rdata[23:0] <= faddr;
          PPS_REG_STAT: rdata[PPS_ST_TAPRST:PPS_ST_BUSY] <=
                          {taprst_f, tsel_f, recov_f, tgt_mode, done,
                           state != PPS_IDLE};
          PPS_REG_DATA: rdata[7:0]  <= prog_byte;
          default:      rdata <= '0;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Serial clock divider
  always_ff @(posedge clk) begin
    if (!rstn) begin
      div_cnt <= 8'h00;
    end else if (ce) begin
      if (tick || state == PPS_IDLE || state == PPS_TGT) begin
        div_cnt <= 8'h00;
      end else begin
        div_cnt <= div_cnt + 8'h01;
      end
    end
  end

  // Transfer engine
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state               <= PPS_IDLE;
      prog_serial_clk_o   <= 1'b0;
      prog_target_sel_n_o <= 1'b1;
      prog_serial_dout    <= 1'b0;
      bitcnt              <= 6'h00;
      bytecnt             <= 16'h0000;
      shreg               <= 32'h0;
      prog_byte           <= 8'h00;
      prog_byte_valid     <= 1'b0;
    end else if (ce) begin
      prog_byte_valid <= 1'b0;
      case (state)
        PPS_IDLE: begin
          bitcnt  <= 6'h00;
          bytecnt <= 16'h0000;
          if (recov_pend || (start && !tgt_mode)) begin
            state               <= PPS_HDR;
            prog_target_sel_n_o <= 1'b0;
            shreg               <= {PPS_READ_CMD, faddr};
            prog_serial_dout    <= PPS_READ_CMD[7];
          end else if (tgt_mode) begin
            state <= PPS_TGT;
          end
        end
        PPS_HDR, PPS_BODY: begin
          if (tick) begin
            prog_serial_clk_o <= !prog_serial_clk_o;
            if (!prog_serial_clk_o) begin
              shreg  <= {shreg[30:0], prog_serial_din};
              bitcnt <= bitcnt + 6'h01;
              if (state == PPS_HDR && bitcnt == PPS_HDR_LAST) begin
                state  <= PPS_BODY;
                bitcnt <= 6'h00;
              end
              if (state == PPS_BODY && bitcnt[2:0] == PPS_BYTE_LAST) begin
                prog_byte       <= rx_byte;
                prog_byte_valid <= 1'b1;
                bytecnt         <= bytecnt + 16'h0001;
                if (bytecnt == len - 16'h0001) begin
                  state <= PPS_FIN;
                end
              end
            end else begin
              prog_serial_dout <= shreg[31];
            end
          end
        end
        PPS_TGT: begin
          if (recov_pend || !tgt_mode) begin
            state <= PPS_IDLE;
          end else if (tsel_f) begin
            bitcnt <= 6'h00;
          end else if (sclk_rise) begin
            shreg  <= {shreg[30:0], din_f};
            bitcnt <= {3'h0, bitcnt[2:0] + 3'h1};
            if (bitcnt[2:0] == PPS_BYTE_LAST) begin
              prog_byte       <= rx_byte;
              prog_byte_valid <= 1'b1;
            end
          end
        end
        PPS_FIN: begin
          prog_serial_clk_o   <= 1'b0;
          prog_target_sel_n_o <= 1'b1;
          state               <= PPS_IDLE;
        end
        default: state <= PPS_IDLE;
      endcase
    end
  end

  // Pin drivers off while a remote master owns the link
  always_ff @(posedge clk) begin
    if (!rstn) begin
      prog_serial_clk_oe   <= 1'b0;
      prog_target_sel_n_oe <= 1'b0;
      prog_serial_dout_oe  <= 1'b0;
    end else if (ce) begin
      prog_serial_clk_oe   <= !tgt_mode && state != PPS_TGT;
      prog_target_sel_n_oe <= !tgt_mode && state != PPS_TGT;
      prog_serial_dout_oe  <= !tgt_mode && state != PPS_TGT;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Live-probe pins
  for (genvar i = 0; i < 2; i++) begin : g_probe
    always_ff @(posedge clk) begin
      if (!rstn) begin
        probe_o[i]  <= 1'b0;
        probe_oe[i] <= 1'b0;
        probe_ie[i] <= 1'b0;
        probe_pu[i] <= 1'b0;
      end else if (ce) begin
        probe_o[i]  <= !prb_res && prb_used && user_probe_o[i];
        probe_oe[i] <= !prb_res && prb_used && user_probe_oe[i];
        probe_ie[i] <= !prb_res && prb_used;
        probe_pu[i] <= !prb_res && !prb_used;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  tgt_oe_a: assert property ((ce && tgt_mode) |=>
    !prog_serial_clk_oe && !prog_serial_dout_oe)
    else $error("serial pins driven in target mode");
  recov_go_a: assert property ((ce && recov_pend &&
    state == PPS_IDLE) |=> state == PPS_HDR)
    else $error("recovery did not start a fetch");
  fetch_sel_a: assert property ((state == PPS_HDR ||
    state == PPS_BODY) |-> !prog_target_sel_n_o)
    else $error("flash not selected during fetch");
  sclk_tog_a: assert property ((ce && tick && state == PPS_HDR) |=>
    prog_serial_clk_o != $past(prog_serial_clk_o))
    else $error("serial clock missed its divided edge");
  fetch_byte_a: assert property ((ce && tick && state == PPS_BODY &&
    !prog_serial_clk_o && bitcnt[2:0] == 3'h7) |=> prog_byte_valid)
    else $error("fetched byte not delivered");
  tgt_byte_a: assert property ((ce && state == PPS_TGT && tgt_mode &&
    !recov_pend && !tsel_f && sclk_rise && bitcnt[2:0] == 3'h7)
    |=> prog_byte_valid ##1 !prog_byte_valid)
    else $error("target byte not delivered");
  probe_res_a: assert property ((ce && prb_res) |=>
    probe_oe == 2'b00 && probe_ie == 2'b00)
    else $error("reserved probe pins not tristated");
  probe_idle_a: assert property ((ce && !prb_res && !prb_used) |=>
    probe_pu == 2'b11 && probe_oe == 2'b00)
    else $error("unused probe pins not parked");

  fetch_end_c: cover property (state == PPS_FIN);
  tgt_rx_c: cover property (state == PPS_TGT && prog_byte_valid);
  recov_c: cover property (recov_pend && state == PPS_IDLE);

endmodule : pps_top

/* pps_flash_model.sv */
`timescale 1ns/1ps
module pps_flash_model (
  // Serial pins as driven by the device
  input  wire logic        sclk,
  input  wire logic        sel_n,
  input  wire logic        mosi,
  // Flash answer and captured header
  output logic             miso,
  output logic [31:0]      hdr
);
  logic [31:0] cnt;
  logic [31:0] idx;
  logic [7:0]  b;

  initial begin
    cnt  = 32'h0;
    miso = 1'b0;
    hdr  = 32'h0;
  end

  // Command and address, then data, msb first
  always @(posedge sclk) begin
    if (!sel_n) begin
      if (cnt < 32) hdr <= {hdr[30:0], mosi};
      cnt <= cnt + 32'h1;
    end
  end

  // Data bytes change on the falling clock
  always @(negedge sclk) begin
    if (!sel_n && cnt >= 32) begin
      idx = cnt - 32'h20;
      b = 8'ha5 ^ idx[10:3];
      miso <= b[~idx[2:0]];
    end
  end

  // Deselected: count cleared and the last bit on the line inverted
  always @(posedge sel_n) begin
    cnt  <= 32'h0;
    miso <= ~miso;
  end
endmodule : pps_flash_model

/* pps_top_tb.sv */
`timescale 1ns/1ps
module pps_top_tb;
  import pps_pkg::*;
  typedef struct packed {
    logic        w;
    logic [3:0]  a;
    logic [31:0] d;
    logic [31:0] m;
    logic [31:0] e;
  } pps_row_t;
  localparam logic [31:0] F = 32'hffffffff;
  localparam pps_row_t ROWS [9] = '{
    '{1'b0, 4'h1, 32'h0, F, 32'h3}, '{1'b0, 4'h2, 32'h0, F, 32'h100},
    '{1'b0, 4'h3, 32'h0, F, 32'h0}, '{1'b0, 4'hf, 32'h0, F, 32'h0},
    '{1'b0, 4'h4, 32'h0, 32'h1f, 32'h18}, '{1'b1, 4'h1, 32'h1, F, 32'h1},
    '{1'b1, 4'h2, 32'h4, F, 32'h4}, '{1'b1, 4'hf, 32'h77, F, 32'h0},
    '{1'b1, 4'h3, 32'h123456, F, 32'h123456}};
  logic clk, rstn, ce, wr, rd, tck, tms, tdi, test_port_reset_n;
  logic tap_port_select, tdo, tdo_oe, dbg_tdo, dbg_tms, dbg_tdi;
  logic dbg_trst_n, prog_serial_clk_i, prog_serial_clk_o;
  logic prog_serial_clk_oe, prog_target_sel_n_i, prog_target_sel_n_o;
  logic prog_target_sel_n_oe, prog_serial_din, prog_serial_dout;
  logic prog_serial_dout_oe, recovery_boot_n, prog_byte_valid;
  logic tb_din, tgt, fl_miso, oe_seen;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata, fl_hdr, cap, v;
  logic [7:0]  prog_byte;
  logic [1:0]  user_probe_o, user_probe_oe, probe_o, probe_oe;
  logic [1:0]  probe_ie, probe_pu;
  logic [7:0]  got[$];
  int          n_fail, n_checks;

  assign prog_serial_din = tgt ? tb_din : fl_miso;

  pps_top uut (.clk, .rstn, .ce, .addr, .wdata, .wr, .rd, .rdata, .tck,
    .tms, .tdi, .test_port_reset_n, .tap_port_select, .tdo, .tdo_oe,
    .dbg_tdo, .dbg_tms, .dbg_tdi, .dbg_trst_n, .prog_serial_clk_i,
    .prog_serial_clk_o, .prog_serial_clk_oe, .prog_target_sel_n_i,
    .prog_target_sel_n_o, .prog_target_sel_n_oe, .prog_serial_din,
    .prog_serial_dout, .prog_serial_dout_oe, .recovery_boot_n, .prog_byte,
    .prog_byte_valid, .user_probe_o, .user_probe_oe, .probe_o, .probe_oe,
    .probe_ie, .probe_pu);

  pps_flash_model fl (.sclk(prog_serial_clk_o), .sel_n(prog_target_sel_n_o),
    .mosi(prog_serial_dout), .miso(fl_miso), .hdr(fl_hdr));

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) if (prog_byte_valid === 1'b1) got.push_back(prog_byte);

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg

  task rreg(input logic [3:0] a, output logic [31:0] q);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 q = rdata;
  endtask : rreg

  task wdone;
    for (int i = 0; i < 400; i++) begin
      rreg(PPS_REG_STAT, v);
      if (v[PPS_ST_DONE] === 1'b1) break;
    end
    chk("done", v[1:0], 32'h2);
    wreg(PPS_REG_STAT, 32'h2);
  endtask : wdone

  task chkfetch;
    chk("hdr", fl_hdr, {PPS_READ_CMD, 24'h123456});
    chk("nbytes", got.size(), 4);
    for (int i = 0; i < 4; i++) chk("byte", got[i], 8'ha5 ^ 8'(i));
    got.delete();
  endtask : chkfetch

  // Test clock only runs inside an access
  task tstep(input logic m, input logic s);
    tms = m;
    #7.5;
    if (s) begin
      cap = {tdo, cap[31:1]};
      oe_seen = oe_seen | tdo_oe;
    end
    tck = 1'b1;
    #7.5 tck = 1'b0;
  endtask : tstep

  task tap_id;
    test_port_reset_n = 1'b1;
    oe_seen = 1'b0;
    repeat (8) tstep(1'b1, 1'b0);
    tstep(1'b0, 1'b0); tstep(1'b1, 1'b0); tstep(1'b0, 1'b0); tstep(1'b0, 1'b0);
    for (int i = 0; i < 32; i++) tstep(i == 31, 1'b1);
    tstep(1'b1, 1'b0); tstep(1'b0, 1'b0);
    test_port_reset_n = 1'b0;
  endtask : tap_id

  // Remote master; a short count drops the partial byte
  task tsend(input logic [7:0] d, input int n);
    prog_target_sel_n_i <= 1'b0;
    repeat (6) @(posedge clk);
    for (int i = 7; i > 7 - n; i--) begin
      tb_din <= d[i];
      repeat (6) @(posedge clk);
      prog_serial_clk_i <= 1'b1;
      repeat (6) @(posedge clk);
      prog_serial_clk_i <= 1'b0;
    end
    repeat (6) @(posedge clk);
    prog_target_sel_n_i <= 1'b1;
    tb_din <= ~tb_din;
  endtask : tsend

  task final_report;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report

  initial begin
    #1000000;
    n_fail++;
    final_report;
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rstn = 1'b0; ce = 1'b1; addr = 4'h0; wdata = 32'h0; wr = 1'b0;
    rd = 1'b0; tck = 1'b0; tms = 1'b1; tdi = 1'b1; dbg_tdo = 1'b0;
    test_port_reset_n = 1'b0;
    tap_port_select = 1'b0;
    prog_serial_clk_i = 1'b0; prog_target_sel_n_i = 1'b1; tb_din = 1'b0;
    tgt = 1'b0; recovery_boot_n = 1'b1; cap = 32'h0; oe_seen = 1'b0;
    user_probe_o = 2'b10; user_probe_oe = 2'b11;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    test_port_reset_n = 1'b1;
    repeat (6) tstep(1'b1, 1'b0);
    tstep(1'b0, 1'b0); tstep(1'b0, 1'b0);
    chk("dbg", {dbg_trst_n, dbg_tms, dbg_tdi}, 32'h5);
    test_port_reset_n = 1'b0;
    foreach (ROWS[i]) begin
      if (ROWS[i].w) wreg(ROWS[i].a, ROWS[i].d);
      rreg(ROWS[i].a, v);
      chk("reg", v & ROWS[i].m, ROWS[i].e);
    end
    for (int p = 0; p < 3; p++) begin
      wreg(PPS_REG_CTRL, (p == 0) ? 32'h4 : (p == 1) ? 32'h8 : 32'h0);
      repeat (2) @(posedge clk);
      chk("probe", {probe_o & probe_oe, probe_oe, probe_ie, probe_pu},
          (p == 0) ? 32'h0 : (p == 1) ? 32'hbc : 32'h3);
    end
    wreg(PPS_REG_CTRL, 32'h1);
    wdone;
    chkfetch;
    recovery_boot_n <= 1'b0;
    wdone;
    chkfetch;
    recovery_boot_n <= 1'b1;
    wreg(PPS_REG_CTRL, 32'h2);
    tgt = 1'b1;
    repeat (4) @(posedge clk);
    rreg(PPS_REG_STAT, v);
    chk("tgt", {v[2], prog_serial_clk_oe, prog_serial_dout_oe}, 32'h4);
    tsend(8'h5a, 8);
    chk("tnum", got.size(), 1);
    chk("tbyte", got[0], 8'h5a);
    tsend(8'hff, 3);
    chk("tdrop", got.size(), 1);
    rstn <= 1'b0;
    tgt = 1'b0;
    tap_port_select = 1'b1;
    repeat (4) @(posedge clk);
    tap_id;
    chk("rstoe", oe_seen, 32'h0);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    tap_id;
    chk("idcode", cap, PPS_IDCODE);
    chk("tdooe", oe_seen, 32'h1);
    final_report;
  end
endmodule : pps_top_tb
